// ===== core/tpm_table_unit.sv
// table pointer move unit: remove-from-bottom and source-to-table
//
// Function
// RL1: remove-bottom copies pointed entry to destination, then decrements stored pointer.
// RL2: remove-bottom moves nothing once the stored pointer is zero.
// RL3: remove-bottom sets the status flag whenever the stored pointer is zero.
// RL4: status flag holds until same-flag instruction runs or scan ends, then clears.
// RL5: program loads the remove-bottom starting pointer itself; device never initialises it.
// RL6: pointer n addresses the word at base address plus n.
// RL7: source-to-table writes source word to pointed entry, incrementing the pointer.
// RL8: source-to-table pointer wraps from table length back to one.
// RL9: each instruction executes once per scan its enabling input is true.
// RL10: program puts table length, 0 to ff, in the first stack level.
// RL11: accumulator holds base address; the base word is pointer store, not data.
// RL12: operand is the source word for copy, the destination for remove.
// RL13: source-to-table moves nothing if pointer lies outside zero through length.
// RL14: source-to-table sets the status flag when pointer equals table length.
// RL15: source-to-table pointer zero or length both address the first entry.
// RL16: program should gate instructions with a one-scan rising edge pulse.
// RL17: pointer and data words update before the instruction completes.
`include "tpm_params.svh"

module tpm_table_unit #(
	parameter int DATA_W = `TPM_DATA_W,
	parameter int ADDR_W = `TPM_ADDR_W,
	parameter int BUF_DEPTH = `TPM_BUF_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// instruction issue from the sequencer
	input wire logic cmdValid,
	output logic cmdReady,
	input wire tpm_pkg::tpm_op_t cmdOp,
	input wire logic cmdEnable,
	input wire logic [`TPM_LEN_W-1:0] cmdLength,
	input wire logic [ADDR_W-1:0] cmdBase,
	input wire logic [ADDR_W-1:0] cmdOperand,
	input wire logic [DATA_W-1:0] cmdData,
	// scan boundary
	input wire logic scanEnd,
	// completion stream
	output logic resValid,
	input wire logic resReady,
	output logic [DATA_W-1:0] resWord,
	output logic [DATA_W-1:0] resPointer,
	output logic resMoved,
	output logic resFlag,
	// status
	output logic tableStatusFlag
);

	localparam int RES_W = 2 * DATA_W + 2;

	typedef struct packed {
		tpm_pkg::tpm_state_t state;
		tpm_pkg::tpm_op_t op;
		logic enable;
		logic [`TPM_LEN_W-1:0] length;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] operand;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] newPtr;
		logic [DATA_W-1:0] word;
		logic moved;
		logic flag;
		logic cmdReady;
		logic memWe;
		logic memRe;
		logic [ADDR_W-1:0] memAddr;
		logic [DATA_W-1:0] memWdata;
		logic pushValid;
	} tpm_core_t;

	tpm_core_t core_q;
	tpm_core_t core_d;
	logic [DATA_W-1:0] memRdata;
	logic bufInReady;
	logic [RES_W-1:0] bufOut;
	logic [DATA_W-1:0] lenWide;
	logic [DATA_W-1:0] ptrEmpty;
	logic [DATA_W-1:0] ptrWrap;
	logic [DATA_W-1:0] ptrStep;
	logic flagWrite;

	// ****************************************
	// parameter checks
	// ****************************************
	if (DATA_W < `TPM_LEN_W) begin : g_chk_data
		$error("tpm_table_unit needs DATA_W at least the length width");
	end
	if (ADDR_W < 1) begin : g_chk_addr
		$error("tpm_table_unit needs ADDR_W of at least 1");
	end

	// constants at the pointer width, so every pointer compare is full width
	// and a stray upper byte can never alias a short length
	assign lenWide = DATA_W'(core_q.length);
	assign ptrEmpty = DATA_W'(`TPM_PTR_EMPTY);
	assign ptrWrap = DATA_W'(`TPM_PTR_WRAP);
	assign ptrStep = DATA_W'(`TPM_PTR_STEP);

	// ****************************************
	// sequencer
	// ****************************************
	// one instruction is worked at a time; the sequencer waits for its result,
	// which costs a few cycles but keeps later instructions seeing new words
	always_comb begin
		core_d = core_q;
		core_d.memWe = 1'b0;
		core_d.memRe = 1'b0;
		core_d.pushValid = 1'b0;
		flagWrite = 1'b0;
		case (core_q.state)
			tpm_pkg::ST_IDLE: begin
				if (cmdValid && core_q.cmdReady) begin
					core_d.cmdReady = 1'b0;
					core_d.op = cmdOp;
					core_d.enable = cmdEnable;
					core_d.length = cmdLength;
					core_d.base = cmdBase; // RL11
					core_d.operand = cmdOperand; // RL12
					core_d.data = cmdData;
					core_d.moved = 1'b0;
					core_d.word = '0;
					core_d.newPtr = '0;
					case (cmdOp)
						tpm_pkg::WRITE_WORD_OP: begin
							// program side store, e.g. the starting pointer
							core_d.memWe = 1'b1;
							core_d.memAddr = cmdOperand;
							core_d.memWdata = cmdData;
							core_d.word = cmdData;
							core_d.state = tpm_pkg::ST_PUSH;
						end
						tpm_pkg::READ_WORD_OP: begin
							core_d.memRe = 1'b1;
							core_d.memAddr = cmdOperand;
							core_d.state = tpm_pkg::ST_DATA_WAIT;
						end
						default: begin
							if (cmdEnable) begin
								// fetch pointer from the base word
								core_d.memRe = 1'b1; // RL9
								core_d.memAddr = cmdBase; // RL11
								core_d.state = tpm_pkg::ST_PTR_WAIT;
							end else begin
								// input false: no execution this scan
								core_d.state = tpm_pkg::ST_PUSH;
							end
						end
					endcase
				end
			end
			tpm_pkg::ST_PTR_WAIT: begin
				// memory answers one cycle after the read is registered
				core_d.state = tpm_pkg::ST_PTR_TAKE;
			end
			tpm_pkg::ST_PTR_TAKE: begin
				// pointer only read here, never initialised by the unit
				if (core_q.op == tpm_pkg::REMOVE_BOTTOM_OP) begin
					// empty table: pointer and destination stay untouched
					if (memRdata == ptrEmpty) begin
						core_d.newPtr = memRdata; // RL2
						core_d.flag = 1'b1; // RL3
						flagWrite = 1'b1;
						core_d.state = tpm_pkg::ST_PUSH;
					end else begin
						core_d.memRe = 1'b1;
						core_d.memAddr = core_q.base + ADDR_W'(memRdata); // RL6
						core_d.newPtr = memRdata - ptrStep; // RL1
						core_d.state = tpm_pkg::ST_DATA_WAIT;
					end
				end else begin
					// a pointer past the length is a program fault: nothing moves
					if (memRdata > lenWide) begin
						core_d.newPtr = memRdata; // RL13
						core_d.flag = 1'b0;
						flagWrite = 1'b1;
						core_d.state = tpm_pkg::ST_PUSH;
					end else begin
						// zero and length both lead to the first entry
						if (memRdata == lenWide) begin
							core_d.newPtr = ptrWrap; // RL8 RL15
						end else begin
							core_d.newPtr = memRdata + ptrStep; // RL7
						end
						core_d.memRe = 1'b1;
						core_d.memAddr = core_q.operand; // RL12
						core_d.state = tpm_pkg::ST_DATA_WAIT;
					end
				end
			end
			tpm_pkg::ST_DATA_WAIT: begin
				core_d.state = tpm_pkg::ST_DATA_TAKE;
			end
			tpm_pkg::ST_DATA_TAKE: begin
				// the fetched word is what every op reaching here reports back
				core_d.word = memRdata;
				if (core_q.op == tpm_pkg::READ_WORD_OP) begin
					core_d.state = tpm_pkg::ST_PUSH;
				end else if (core_q.op == tpm_pkg::REMOVE_BOTTOM_OP) begin
					core_d.memWe = 1'b1;
					core_d.memAddr = core_q.operand; // RL1
					core_d.memWdata = memRdata;
					core_d.state = tpm_pkg::ST_WR_PTR;
				end else begin
					core_d.memWe = 1'b1;
					core_d.memAddr = core_q.base + ADDR_W'(core_q.newPtr); // RL6 RL15
					core_d.memWdata = memRdata; // RL7
					core_d.state = tpm_pkg::ST_WR_PTR;
				end
			end
			tpm_pkg::ST_WR_PTR: begin
				// pointer word written back before the result leaves
				core_d.memWe = 1'b1;
				core_d.memAddr = core_q.base; // RL17
				core_d.memWdata = core_q.newPtr;
				core_d.moved = 1'b1;
				flagWrite = 1'b1;
				if (core_q.op == tpm_pkg::REMOVE_BOTTOM_OP) begin
					core_d.flag = (core_q.newPtr == ptrEmpty); // RL3
				end else begin
					core_d.flag = (core_q.newPtr == lenWide); // RL14
				end
				core_d.state = tpm_pkg::ST_PUSH;
			end
			tpm_pkg::ST_PUSH: begin
				// stall here while the result buffer is full
				if (bufInReady) begin
					core_d.pushValid = 1'b1;
					core_d.cmdReady = 1'b1;
					core_d.state = tpm_pkg::ST_IDLE;
				end
			end
			default: begin
				core_d.state = tpm_pkg::ST_IDLE;
				core_d.cmdReady = 1'b1;
			end
		endcase
		// a scan end clears the flag unless an instruction writes it now
		if (scanEnd && !flagWrite) begin
			core_d.flag = 1'b0; // RL4
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			core_q <= '0;
			core_q.state <= tpm_pkg::ST_IDLE;
			core_q.op <= tpm_pkg::REMOVE_BOTTOM_OP;
			core_q.cmdReady <= 1'b1;
		end else begin
			core_q <= core_d;
		end
	end

	// ****************************************
	// word memory
	// ****************************************
	tpm_word_mem #(
		.DATA_W(DATA_W),
		.ADDR_W(ADDR_W)
	) u_mem (
		.clk(clk),
		.wrEn(core_q.memWe),
		.wrAddr(core_q.memAddr),
		.wrData(core_q.memWdata),
		.rdEn(core_q.memRe),
		.rdAddr(core_q.memAddr),
		.rdData(memRdata)
	);

	// ****************************************
	// result buffer
	// ****************************************
	// only one push per instruction and pops only add room, so ready sampled
	// a cycle before the registered push is still true
	tpm_result_buf #(
		.WIDTH(RES_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.reset(reset),
		.inValid(core_q.pushValid),
		.inReady(bufInReady),
		.inData({core_q.moved, core_q.flag, core_q.newPtr, core_q.word}),
		.outValid(resValid),
		.outReady(resReady),
		.outData(bufOut)
	);

	// output fields
	assign resMoved = bufOut[RES_W-1];
	assign resFlag = bufOut[RES_W-2];
	assign resPointer = bufOut[2*DATA_W-1:DATA_W];
	assign resWord = bufOut[DATA_W-1:0];
	assign cmdReady = core_q.cmdReady;
	assign tableStatusFlag = core_q.flag;

endmodule : tpm_table_unit

// ===== core/tpm_params.svh
// constants for the table pointer move unit
`ifndef TPM_PARAMS_SVH
`define TPM_PARAMS_SVH

// ****************************************
// widths
// ****************************************
`define TPM_DATA_W 16
`define TPM_ADDR_W 10
`define TPM_LEN_W 8
`define TPM_BUF_DEPTH 2

// ****************************************
// pointer values
// ****************************************
`define TPM_PTR_EMPTY 0
`define TPM_PTR_WRAP 1
`define TPM_PTR_STEP 1

`endif

// ===== core/tpm_pkg.sv
// types shared by the table pointer move unit
package tpm_pkg;

	// ****************************************
	// instruction codes
	// ****************************************
	typedef enum logic [1:0] {
		REMOVE_BOTTOM_OP = 2'h0,
		COPY_INTO_TABLE_OP = 2'h1,
		WRITE_WORD_OP = 2'h2,
		READ_WORD_OP = 2'h3
	} tpm_op_t;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PTR_WAIT = 3'h1,
		ST_PTR_TAKE = 3'h2,
		ST_DATA_WAIT = 3'h3,
		ST_DATA_TAKE = 3'h4,
		ST_WR_PTR = 3'h5,
		ST_PUSH = 3'h6
	} tpm_state_t;

endpackage : tpm_pkg

// ===== core/tpm_word_mem.sv
// word memory holding pointer words, tables and operands
module tpm_word_mem #(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 10
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	// read port, one cycle latency
	input wire logic rdEn,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);

	// ****************************************
	// storage
	// ****************************************
	logic [DATA_W-1:0] words [0:(1<<ADDR_W)-1];

	// no reset on the array: contents belong to the program
	always_ff @(posedge clk) begin
		if (wrEn) begin
			words[wrAddr] <= wrData;
		end
		if (rdEn) begin
			rdData <= words[rdAddr];
		end
	end

endmodule : tpm_word_mem

// ===== core/tpm_result_buf.sv
// small shift buffer with valid and ready on both sides
module tpm_result_buf #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	typedef struct packed {
		logic [DEPTH-1:0] vld;
		logic [DEPTH-1:0][WIDTH-1:0] slot;
	} tpm_buf_t;

	tpm_buf_t buf_q;
	tpm_buf_t buf_d;
	logic pop;
	logic push;
	logic [DEPTH:0] shVld;
	logic [DEPTH-1:0] nxtVld;
	logic [DEPTH-1:0][WIDTH-1:0] nxtSlot;

	if (DEPTH < 2) begin : g_chk
		$error("tpm_result_buf needs DEPTH of at least 2");
	end

	// head always sits in slot 0, so the outputs are plain flops
	assign pop = outReady & buf_q.vld[0];
	assign push = inValid & ~buf_q.vld[DEPTH-1];
	assign shVld[DEPTH] = 1'b0;

	// ****************************************
	// per slot shift and fill
	// ****************************************
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		logic [WIDTH-1:0] upper;
		logic below;
		logic fillHere;
		assign upper = (i == DEPTH - 1) ? '0 : buf_q.slot[(i + 1) % DEPTH];
		assign shVld[i] = pop ? ((i == DEPTH - 1) ? 1'b0 : buf_q.vld[(i + 1) % DEPTH])
			: buf_q.vld[i];
		assign below = (i == 0) ? 1'b1 : shVld[(i + DEPTH - 1) % DEPTH];
		assign fillHere = push & ~shVld[i] & below;
		assign nxtVld[i] = shVld[i] | fillHere;
		assign nxtSlot[i] = fillHere ? inData : (pop ? upper : buf_q.slot[i]);
	end

	// next state assembly
	always_comb begin
		buf_d = buf_q;
		buf_d.vld = nxtVld;
		buf_d.slot = nxtSlot;
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			buf_q <= '0;
		end else begin
			buf_q <= buf_d;
		end
	end

	assign inReady = ~buf_q.vld[DEPTH-1];
	assign outValid = buf_q.vld[0];
	assign outData = buf_q.slot[0];

endmodule : tpm_result_buf

// ===== bench/tpm_table_unit_asserts.sv
// checker watching the ports of the table pointer move unit
module tpm_table_unit_asserts #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// instruction side
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic scanEnd,
	// result side
	input wire logic resValid,
	input wire logic resReady,
	input wire logic [DATA_W-1:0] resWord,
	input wire logic [DATA_W-1:0] resPointer,
	input wire logic resMoved,
	input wire logic resFlag,
	input wire logic tableStatusFlag
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// properties
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// an accepted instruction
	sequence sTake;
		cmdValid && cmdReady;
	endsequence
	// scan closes while no flag writer can be pending
	sequence sIdleEnd;
		cmdReady && scanEnd;
	endsequence
	a_take_once: assert property (sTake |=> !cmdReady)
		else $error("instruction accepted twice");
	a_ready_return: assert property ((sTake and !resValid) |-> ##[1:7] cmdReady)
		else $error("instruction did not complete in time");
	a_scan_clear: assert property (sIdleEnd |=> !tableStatusFlag)
		else $error("flag survived end of scan");
	a_flag_hold: assert property (cmdReady && !scanEnd |=> $stable(tableStatusFlag))
		else $error("flag changed with no instruction");
	a_flag_busy: assert property ($rose(tableStatusFlag) |-> !cmdReady)
		else $error("flag set outside an instruction");
	a_res_hold: assert property (resValid && !resReady |=>
		resValid && $stable(resWord) && $stable(resPointer))
		else $error("stalled result lost");
	a_empty_flag: assert property (resValid && resMoved && resPointer == 16'h0 |-> resFlag)
		else $error("empty pointer without flag");
	// ready returns with the push, so a back-to-back take may already have lowered it
	a_push_ready: assert property ($rose(resValid) |-> $past(cmdReady))
		else $error("result without completion");
endmodule : tpm_table_unit_asserts

bind tpm_table_unit tpm_table_unit_asserts #(.DATA_W(DATA_W)) i_chk (
	.clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.scanEnd(scanEnd), .resValid(resValid), .resReady(resReady), .resWord(resWord),
	.resPointer(resPointer), .resMoved(resMoved), .resFlag(resFlag),
	.tableStatusFlag(tableStatusFlag)
);

// ===== bench/tpm_seq_model.sv
// sequencer model issuing table instructions and taking results
module tpm_seq_model (
	// clock
	input wire logic clk,
	// instruction issue
	output logic cmdValid,
	input wire logic cmdReady,
	output tpm_pkg::tpm_op_t cmdOp,
	output logic cmdEnable,
	output logic [7:0] cmdLength,
	output logic [9:0] cmdBase,
	output logic [9:0] cmdOperand,
	output logic [15:0] cmdData,
	// results
	input wire logic resValid,
	output logic resReady,
	input wire logic [15:0] resWord,
	input wire logic [15:0] resPointer,
	input wire logic resMoved,
	input wire logic resFlag
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// issue and take
	// ********
	initial begin
		{cmdValid, cmdEnable, resReady} = 3'h0;
		{cmdOp, cmdLength, cmdBase, cmdOperand, cmdData} = '0;
	end
	// one rung per call, so each call moves at most one value
	task automatic issue(input tpm_pkg::tpm_op_t op, input logic en, input logic [7:0] len,
		input logic [9:0] base, input logic [9:0] opnd, input logic [15:0] data);
		@(posedge clk);
		cmdValid <= 1'h1;
		cmdOp <= op;
		cmdEnable <= en;
		cmdLength <= len;
		cmdBase <= base;
		cmdOperand <= opnd;
		cmdData <= data;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			if (cmdReady) break;
		end
		cmdValid <= 1'h0;
		// released operand and data lines carry junk so stale values are never taken as live
		cmdOperand <= ~opnd;
		cmdData <= ~data;
	endtask : issue
	// ready only while waiting, so results queue up between calls
	task automatic take(output logic [15:0] w, p, output logic m, f);
		@(posedge clk);
		resReady <= 1'h1;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			if (resValid) break;
		end
		{w, p, m, f} = {resWord, resPointer, resMoved, resFlag};
		resReady <= 1'h0;
	endtask : take
endmodule : tpm_seq_model

// ===== bench/tpm_table_unit_tb.sv
// testbench for the table pointer move unit
module tpm_table_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam tpm_pkg::tpm_op_t rmOp = tpm_pkg::REMOVE_BOTTOM_OP;
	localparam tpm_pkg::tpm_op_t cpOp = tpm_pkg::COPY_INTO_TABLE_OP;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic scanEnd = 1'h0;
	logic cmdValid, cmdReady, cmdEnable, resValid, resReady, resMoved, resFlag, tableStatusFlag;
	tpm_pkg::tpm_op_t cmdOp;
	logic [7:0] cmdLength;
	logic [9:0] cmdBase, cmdOperand;
	logic [15:0] cmdData, resWord, resPointer, w, p;
	logic m, f;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;

	// ********
	// harness
	// ********
	always #20 clk = ~clk;
	tpm_table_unit i_dut (.clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdOp(cmdOp), .cmdEnable(cmdEnable), .cmdLength(cmdLength), .cmdBase(cmdBase),
		.cmdOperand(cmdOperand), .cmdData(cmdData), .scanEnd(scanEnd), .resValid(resValid),
		.resReady(resReady), .resWord(resWord), .resPointer(resPointer), .resMoved(resMoved),
		.resFlag(resFlag), .tableStatusFlag(tableStatusFlag));
	tpm_seq_model i_seq (.clk(clk), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdEnable(cmdEnable), .cmdLength(cmdLength), .cmdBase(cmdBase),
		.cmdOperand(cmdOperand), .cmdData(cmdData), .resValid(resValid),
		.resReady(resReady), .resWord(resWord), .resPointer(resPointer),
		.resMoved(resMoved), .resFlag(resFlag));

	task automatic check(input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic run(input tpm_pkg::tpm_op_t op, input logic en, input logic [7:0] len,
		input logic [9:0] b, o, input logic [15:0] d);
		i_seq.issue(op, en, len, b, o, d);
		i_seq.take(w, p, m, f);
	endtask : run
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		run(tpm_pkg::WRITE_WORD_OP, 1'h1, 8'h00, 10'h000, a, d);
	endtask : wr
	task automatic rd(input logic [9:0] a);
		run(tpm_pkg::READ_WORD_OP, 1'h1, 8'h00, 10'h000, a, 16'h0000);
	endtask : rd
	task automatic end_scan;
		@(posedge clk) scanEnd <= 1'h1;
		@(posedge clk) scanEnd <= 1'h0;
		@(posedge clk);
	endtask : end_scan

	// ********
	// scenarios
	// ********
	// drain a three-entry table down past empty
	task automatic s_remove_bottom;
		for (int i = 1; i <= 3; i++) wr(10'h040 + 10'(i), 16'h0a00 + 16'(i));
		wr(10'h040, 16'h0003);
		for (int i = 3; i >= 0; i--) begin
			run(rmOp, 1'h1, 8'h03, 10'h040, 10'h100, 16'h0000);
			check(w, i ? 16'h0a00 + 16'(i) : 16'h0000);
			check(p, i ? 16'(i - 1) : 16'h0000);
			check(m, i != 0);
			check(f, i <= 1);
			check(tableStatusFlag, i <= 1);
			end_scan();
			check(tableStatusFlag, 1'h0);
			rd(10'h100);
			check(w, 16'h0a00 + 16'(i ? i : 1));
		end
	endtask : s_remove_bottom
	// fill past the end without closing the scan
	task automatic s_copy_into_table;
		wr(10'h080, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			wr(10'h110, 16'h0b00 + 16'(k));
			run(cpOp, 1'h1, 8'h03, 10'h080, 10'h110, 16'h0000);
			check(p, 16'((k % 3) + 1));
			check(m, 1'h1);
			check(f, k % 3 == 2);
		end
		rd(10'h081);
		check(w, 16'h0b03);
		rd(10'h083);
		check(w, 16'h0b02);
	endtask : s_copy_into_table
	// pointer one past the length after a flag was raised
	task automatic s_out_of_range;
		wr(10'h080, 16'h0002);
		run(cpOp, 1'h1, 8'h03, 10'h080, 10'h110, 16'h0000);
		check(tableStatusFlag, 1'h1);
		wr(10'h080, 16'h0004);
		run(cpOp, 1'h1, 8'h03, 10'h080, 10'h110, 16'h0000);
		check(m, 1'h0);
		check(p, 16'h0004);
		check(tableStatusFlag, 1'h0);
		rd(10'h081);
		check(w, 16'h0b03);
	endtask : s_out_of_range
	// rung false: nothing moves
	task automatic s_disabled;
		wr(10'h080, 16'h0001);
		run(cpOp, 1'h0, 8'h03, 10'h080, 10'h110, 16'h0000);
		check(m, 1'h0);
		rd(10'h080);
		check(w, 16'h0001);
		rd(10'h082);
		check(w, 16'h0b04);
		wr(10'h040, 16'h0002);
		run(rmOp, 1'h0, 8'h03, 10'h040, 10'h100, 16'h0000);
		check(m, 1'h0);
		rd(10'h040);
		check(w, 16'h0002);
		rd(10'h100);
		check(w, 16'h0a01);
	endtask : s_disabled
	// receiver stalls while three results pile up
	task automatic s_stall;
		for (int i = 0; i < 3; i++) i_seq.issue(tpm_pkg::WRITE_WORD_OP, 1'h1, 8'h00, 10'h000,
			10'h120 + 10'(i), 16'h0c00 + 16'(i));
		repeat (4) @(posedge clk);
		check(cmdReady, 1'h0);
		for (int i = 0; i < 3; i++) begin
			i_seq.take(w, p, m, f);
			check(w, 16'h0c00 + 16'(i));
		end
	endtask : s_stall

	// ********
	// sequence and verdict
	// ********
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// the run needs about three hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'h0;
		s_remove_bottom();
		s_copy_into_table();
		s_out_of_range();
		s_disabled();
		s_stall();
		complete_run();
	end
endmodule : tpm_table_unit_tb
